//--- rtl/transport_pkg.sv
// Constants shared by the transport header router and its helpers.
// Assumes one clock domain and header fields presented in parallel.
// Contract
// - Both identifiers share one width, 8 or 16
// - Code 0 small, 1 large, others reserved
// - Format type is the first four bits
// - Sender writes destination into target identifier
// - Sender writes own identifier as origin
// - Response swaps request origin and target
// - Forwarding chosen from target identifier
// - Ring element removes packets matching itself
// - Ring element passes others on unchanged
// - Switch table maps target to output port
// - Identifierless switch accepts hop count zero
// - Nonzero hop count decremented then forwarded
// - Maintenance responses carry hop count all ones
// - Device recognises every identifier it owns
package transport_pkg;
   // Transport type codes
   localparam logic [1:0] TT_SMALL = 2'h0;
   localparam logic [1:0] TT_LARGE = 2'h1;
   // Field widths
   localparam int FTYPE_W = 4;
   localparam int ID_W = 16;
   localparam int ID_SMALL_W = 8;
   localparam int HOP_W = 8;
   localparam int PORT_W = 4;
   localparam int TBL_AW = 8;
   // Hop count stamped on maintenance responses
   localparam logic [7:0] HOP_RESP = 8'hff;
   localparam logic [7:0] HOP_ZERO = 8'h00;
   localparam logic [7:0] HOP_ONE = 8'h01;
   // Ring downstream port
   localparam logic [3:0] RING_PORT = 4'h0;
   // Receive FIFO word layout {tt, ftype, target, origin, maint, hop}
   localparam int RX_W = 2 + FTYPE_W + ID_W + ID_W + 1 + HOP_W;
   localparam int RX_D = 8;
   localparam int F_HOP = 0;
   localparam int F_MAINT = 8;
   localparam int F_ORG = 9;
   localparam int F_TGT = 25;
   localparam int F_FT = 41;
   localparam int F_TT = 45;
   // Transmit header {tt, ftype, target, origin}, left aligned
   localparam int TX_HDR_W = 2 + FTYPE_W + ID_W + ID_W;
   // Router states
   typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_SEND} route_state_t;
endpackage

//--- rtl/route_table_mem.sv
// Route table storage: one output port per target identifier index.
// Assumes writes come from local configuration logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module route_table_mem (
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [transport_pkg::TBL_AW-1:0] wr_addr,
   input wire logic [transport_pkg::PORT_W-1:0] wr_data,
   input wire logic [transport_pkg::TBL_AW-1:0] rd_addr,
   output logic [transport_pkg::PORT_W-1:0] rd_data_ff
);
   // Table contents, one entry per index
   logic [transport_pkg::PORT_W-1:0] mem_ff [0:(1<<transport_pkg::TBL_AW)-1];

   // Write port
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem_ff[wr_addr] <= wr_data;
      end
   end

   // Registered read, data one cycle after address
   always_ff @(posedge ref_clk) begin
      rd_data_ff <= mem_ff[rd_addr];
   end
endmodule // route_table_mem
`default_nettype wire

//--- rtl/header_fifo.sv
// Synchronous FIFO holding received headers between link and router.
// Assumes both sides run on ref_clk; full and empty come from flops.
`timescale 1ns/1ps
`default_nettype none
module header_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   // Storage and pointers
   logic [W-1:0] mem_ff [0:D-1];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic full_ff;
   logic empty_ff;
   logic push;
   logic pop;
   logic [AW:0] nxt_count;

   // Handshakes
   assign push = in_valid && !full_ff;
   assign pop = out_ready && !empty_ff;
   assign in_ready = !full_ff;
   assign out_valid = !empty_ff;
   assign out_data = mem_ff[rd_ptr_ff];

   // Occupancy after this cycle
   always_comb begin
      nxt_count = count_ff;
      if (push && !pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   // Pointers and flags
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
         full_ff <= 1'b0;
         empty_ff <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(D-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(D-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         count_ff <= nxt_count;
         full_ff <= (nxt_count == (AW+1)'(D));
         empty_ff <= (nxt_count == '0);
      end
   end

   // Data write
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end
endmodule // header_fifo
`default_nettype wire

//--- rtl/transport_header_router.sv
// Transport header router: builds outgoing headers and routes incoming ones.
// Assumes link and local logic share ref_clk; fields arrive in parallel.
// Reserved transport codes are dropped at the queue head and flagged.
`timescale 1ns/1ps
`default_nettype none
module transport_header_router (
   input wire logic ref_clk,
   input wire logic reset,
   // Configuration
   input wire logic ring_mode,
   input wire logic has_own_id,
   input wire logic [transport_pkg::ID_W-1:0] own_id,
   input wire logic alt_id_en,
   input wire logic [transport_pkg::ID_W-1:0] alt_id,
   input wire logic tbl_wr_en,
   input wire logic [transport_pkg::TBL_AW-1:0] tbl_wr_addr,
   input wire logic [transport_pkg::PORT_W-1:0] tbl_wr_port,
   // Received headers
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [1:0] rx_tt,
   input wire logic [transport_pkg::FTYPE_W-1:0] rx_ftype,
   input wire logic [transport_pkg::ID_W-1:0] rx_target,
   input wire logic [transport_pkg::ID_W-1:0] rx_origin,
   input wire logic rx_maint,
   input wire logic [transport_pkg::HOP_W-1:0] rx_hop,
   // Routed header fields
   output logic [1:0] hdr_tt_ff,
   output logic [transport_pkg::FTYPE_W-1:0] hdr_ftype_ff,
   output logic [transport_pkg::ID_W-1:0] hdr_target_ff,
   output logic [transport_pkg::ID_W-1:0] hdr_origin_ff,
   output logic hdr_maint_ff,
   output logic [transport_pkg::HOP_W-1:0] hdr_hop_ff,
   output logic dlv_valid_ff,
   input wire logic dlv_ready,
   output logic fwd_valid_ff,
   input wire logic fwd_ready,
   output logic [transport_pkg::PORT_W-1:0] fwd_port_ff,
   output logic tt_error_ff,
   // Local generation requests
   input wire logic gen_valid,
   output logic gen_ready_ff,
   input wire logic [transport_pkg::FTYPE_W-1:0] gen_ftype,
   input wire logic gen_wide,
   input wire logic gen_is_resp,
   input wire logic gen_maint,
   input wire logic [transport_pkg::ID_W-1:0] gen_peer_id,
   input wire logic [transport_pkg::ID_W-1:0] gen_req_target,
   input wire logic [transport_pkg::HOP_W-1:0] gen_hop,
   // Generated headers
   output logic tx_valid_ff,
   input wire logic tx_ready,
   output logic [transport_pkg::TX_HDR_W-1:0] tx_header_ff,
   output logic tx_wide_ff,
   output logic tx_maint_ff,
   output logic [transport_pkg::HOP_W-1:0] tx_hop_ff
);
   // FIFO side signals
   logic [transport_pkg::RX_W-1:0] rx_word;
   logic [transport_pkg::RX_W-1:0] q_word;
   logic q_valid;
   logic q_ready;
   logic [transport_pkg::PORT_W-1:0] tbl_port;

   // Router state
   transport_pkg::route_state_t state_ff;
   transport_pkg::route_state_t nxt_state;

   // Unpacked queue head
   logic [1:0] q_tt;
   logic [transport_pkg::ID_W-1:0] q_tgt;
   // Head carries a defined size code
   logic code_ok;

   // Decision terms from held header
   logic wide_id;
   logic id_match;
   logic hop_zero;
   logic take_local;
   logic by_hop;

   // Handshake done terms
   logic dlv_done;
   logic fwd_done;

   // Egress next values
   logic gen_take;
   logic nxt_tx_valid;
   logic [transport_pkg::ID_W-1:0] gen_tgt;
   logic [transport_pkg::ID_W-1:0] gen_org;

   // ftype kept beside the transport code
   assign rx_word = {rx_tt, rx_ftype, rx_target, rx_origin, rx_maint, rx_hop};
   // Head fields looked at before the pop
   assign q_tt = q_word[transport_pkg::F_TT +: 2];
   assign q_tgt = q_word[transport_pkg::F_TGT +: transport_pkg::ID_W];
   assign code_ok = (q_tt == transport_pkg::TT_SMALL) || (q_tt == transport_pkg::TT_LARGE);

   // Receive buffer between link and router
   header_fifo #(
      .W(transport_pkg::RX_W),
      .D(transport_pkg::RX_D)
   ) u_rx_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      // Link side
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_word),
      // Router side
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_word)
   );

   // target to port table
   // Read address is the head, data lands with the pop
   route_table_mem u_route_table (
      .ref_clk(ref_clk),
      .wr_en(tbl_wr_en),
      .wr_addr(tbl_wr_addr),
      .wr_data(tbl_wr_port),
      .rd_addr(q_tgt[transport_pkg::TBL_AW-1:0]),
      .rd_data_ff(tbl_port)
   );

   // Router pops only when idle
   assign q_ready = (state_ff == transport_pkg::ST_IDLE);
   // Handshake completes on valid and ready
   assign dlv_done = dlv_valid_ff && dlv_ready;
   assign fwd_done = fwd_valid_ff && fwd_ready;

   assign wide_id = (hdr_tt_ff == transport_pkg::TT_LARGE);

   // Compare held target against owned identifiers
   always_comb begin
      // Default no match
      id_match = 1'b0;
      // Width follows the held code
      if (wide_id) begin
         id_match = (hdr_target_ff == own_id) || (alt_id_en && (hdr_target_ff == alt_id));
      end else begin
         // Small code compares low byte
         id_match = (hdr_target_ff[transport_pkg::ID_SMALL_W-1:0] ==
                     own_id[transport_pkg::ID_SMALL_W-1:0]) ||
                    (alt_id_en && (hdr_target_ff[transport_pkg::ID_SMALL_W-1:0] ==
                     alt_id[transport_pkg::ID_SMALL_W-1:0]));
      end
   end

   // Local acceptance decision
   always_comb begin
      hop_zero = (hdr_hop_ff == transport_pkg::HOP_ZERO);
      // identifierless switch addresses maintenance by hops
      by_hop = !ring_mode && !has_own_id && hdr_maint_ff;
      if (by_hop) begin
         take_local = hop_zero;
      end else begin
         take_local = has_own_id && id_match;
      end
   end

   // Router state sequence
   always_comb begin
      // Hold by default
      nxt_state = state_ff;
      case (state_ff)
         transport_pkg::ST_IDLE: begin
            // Reserved codes are popped, stay idle
            if (q_valid && code_ok) begin
               nxt_state = transport_pkg::ST_LOOKUP;
            end
         end
         transport_pkg::ST_LOOKUP: begin
            // Table read settles here
            nxt_state = transport_pkg::ST_SEND;
         end
         transport_pkg::ST_SEND: begin
            // Wait for the chosen consumer
            if (dlv_done || fwd_done) begin
               nxt_state = transport_pkg::ST_IDLE;
            end
         end
         default: begin
            // Unused encoding returns idle
            nxt_state = transport_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // Start idle
         state_ff <= transport_pkg::ST_IDLE;
      end else begin
         // Advance one step
         state_ff <= nxt_state;
      end
   end

   // Capture header at pop, decrement hop on hop-addressed forward
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // Cleared fields, small code
         hdr_tt_ff <= transport_pkg::TT_SMALL;
         hdr_ftype_ff <= '0;
         hdr_target_ff <= '0;
         hdr_origin_ff <= '0;
         hdr_maint_ff <= 1'b0;
         hdr_hop_ff <= transport_pkg::HOP_ZERO;
      end else if (state_ff == transport_pkg::ST_IDLE && q_valid && code_ok) begin
         // Fields of a defined code only
         hdr_tt_ff <= q_tt;
         hdr_ftype_ff <= q_word[transport_pkg::F_FT +: transport_pkg::FTYPE_W];
         hdr_target_ff <= q_tgt;
         hdr_origin_ff <= q_word[transport_pkg::F_ORG +: transport_pkg::ID_W];
         hdr_maint_ff <= q_word[transport_pkg::F_MAINT];
         hdr_hop_ff <= q_word[transport_pkg::F_HOP +: transport_pkg::HOP_W];
      // Hop-addressed packet passing through
      end else if (state_ff == transport_pkg::ST_LOOKUP && by_hop && !hop_zero) begin
         hdr_hop_ff <= hdr_hop_ff - transport_pkg::HOP_ONE;
      end
   end

   // Delivery and forward strobes with chosen port
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // Idle strobes, ring port parked
         dlv_valid_ff <= 1'b0;
         fwd_valid_ff <= 1'b0;
         fwd_port_ff <= transport_pkg::RING_PORT;
      end else if (state_ff == transport_pkg::ST_LOOKUP) begin
         // Exactly one consumer chosen
         dlv_valid_ff <= take_local;
         fwd_valid_ff <= !take_local;
         // Port matters only on forward
         if (ring_mode) begin
            fwd_port_ff <= transport_pkg::RING_PORT;
         end else begin
            fwd_port_ff <= tbl_port;
         end
      end else begin
         // Drop each strobe after its handshake
         if (dlv_done) begin
            dlv_valid_ff <= 1'b0;
         end
         if (fwd_done) begin
            fwd_valid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // No error after reset
         tt_error_ff <= 1'b0;
      end else begin
         // One pulse per discarded header
         tt_error_ff <= (state_ff == transport_pkg::ST_IDLE) && q_valid && !code_ok;
      end
   end

   // Egress acceptance
   assign gen_take = gen_valid && gen_ready_ff;

   // Next transmit valid
   always_comb begin
      nxt_tx_valid = tx_valid_ff;
      if (gen_take) begin
         // Accepted request raises valid
         nxt_tx_valid = 1'b1;
      end else if (tx_ready) begin
         // Far side took the header
         nxt_tx_valid = 1'b0;
      end
   end

   // Identifier selection for new headers
   always_comb begin
      if (gen_is_resp) begin
         gen_tgt = gen_peer_id;
         gen_org = gen_req_target;
      end else begin
         gen_tgt = gen_peer_id;
         gen_org = own_id;
      end
   end

   // Transmit handshake registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // Nothing pending, not ready in reset
         tx_valid_ff <= 1'b0;
         gen_ready_ff <= 1'b0;
      end else begin
         // Ready low exactly while a header waits
         tx_valid_ff <= nxt_tx_valid;
         gen_ready_ff <= !nxt_tx_valid;
      end
   end

   // Header assembly on acceptance
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // Cleared header
         tx_header_ff <= '0;
         tx_wide_ff <= 1'b0;
         tx_maint_ff <= 1'b0;
         tx_hop_ff <= transport_pkg::HOP_ZERO;
      end else if (gen_take) begin
         // Width and kind travel beside it
         tx_wide_ff <= gen_wide;
         tx_maint_ff <= gen_maint;
         if (gen_wide) begin
            tx_header_ff <= {transport_pkg::TT_LARGE, gen_ftype, gen_tgt, gen_org};
         end else begin
            tx_header_ff <= {transport_pkg::TT_SMALL, gen_ftype,
                             gen_tgt[transport_pkg::ID_SMALL_W-1:0],
                             gen_org[transport_pkg::ID_SMALL_W-1:0],
                             {(2*(transport_pkg::ID_W-transport_pkg::ID_SMALL_W)){1'b0}}};
         end
         if (gen_maint && gen_is_resp) begin
            tx_hop_ff <= transport_pkg::HOP_RESP;
         end else begin
            // Others keep the caller's hop
            tx_hop_ff <= gen_hop;
         end
      end
   end
endmodule // transport_header_router
`default_nettype wire

//--- bench/transport_header_router_assertions.sv
// Concurrent checks on the transport header router top ports.
// Assumes the single ref_clk domain with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module router_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ring_mode,
   input wire logic [15:0] own_id,
   input wire logic dlv_valid_ff,
   input wire logic dlv_ready,
   input wire logic fwd_valid_ff,
   input wire logic fwd_ready,
   input wire logic [3:0] fwd_port_ff,
   input wire logic [15:0] hdr_target_ff,
   input wire logic tt_error_ff,
   input wire logic gen_valid,
   input wire logic gen_ready_ff,
   input wire logic gen_is_resp,
   input wire logic gen_maint,
   input wire logic gen_wide,
   input wire logic tx_valid_ff,
   input wire logic tx_ready,
   input wire logic [37:0] tx_header_ff,
   input wire logic tx_wide_ff,
   input wire logic [7:0] tx_hop_ff
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Generation request taken this edge
   wire logic take_gen = gen_valid && gen_ready_ff;
   property p_err_pulse; tt_error_ff |=> !tt_error_ff; endproperty
   a_err_pulse: assert property (p_err_pulse) else $error("error flag held too long");
   property p_one_way; !(dlv_valid_ff && fwd_valid_ff); endproperty
   a_one_way: assert property (p_one_way) else $error("deliver and forward together");
   property p_dlv_hold; dlv_valid_ff && !dlv_ready |=> dlv_valid_ff && $stable(hdr_target_ff); endproperty
   a_dlv_hold: assert property (p_dlv_hold) else $error("delivery dropped early");
   property p_fwd_hold; fwd_valid_ff && !fwd_ready |=> fwd_valid_ff && $stable(fwd_port_ff); endproperty
   a_fwd_hold: assert property (p_fwd_hold) else $error("forward dropped early");
   property p_ring_port; ring_mode && fwd_valid_ff |-> fwd_port_ff == 4'h0; endproperty
   a_ring_port: assert property (p_ring_port) else $error("ring forward off port zero");
   property p_tt_code; tx_valid_ff |-> tx_header_ff[37:36] == {1'b0, tx_wide_ff}; endproperty
   a_tt_code: assert property (p_tt_code) else $error("bad transport code sent");
   property p_resp_hop; take_gen && gen_maint && gen_is_resp |=> tx_hop_ff == 8'hff; endproperty
   a_resp_hop: assert property (p_resp_hop) else $error("response hop not all ones");
   property p_req_origin; take_gen && gen_wide && !gen_is_resp |=> tx_header_ff[15:0] == own_id; endproperty
   a_req_origin: assert property (p_req_origin) else $error("request origin wrong");
   property p_tx_hold; tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_header_ff); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("header dropped early");
   // Main scenarios reached
   c_dlv: cover property (dlv_valid_ff && dlv_ready);
   c_fwd: cover property (fwd_valid_ff && fwd_ready && !ring_mode);
   c_err: cover property (tt_error_ff);
endmodule // router_checker
bind transport_header_router router_checker router_checker_inst (.ref_clk, .reset, .ring_mode, .own_id,
   .dlv_valid_ff, .dlv_ready, .fwd_valid_ff, .fwd_ready, .fwd_port_ff, .hdr_target_ff, .tt_error_ff,
   .gen_valid, .gen_ready_ff, .gen_is_resp, .gen_maint, .gen_wide, .tx_valid_ff, .tx_ready,
   .tx_header_ff, .tx_wide_ff, .tx_hop_ff);
`default_nettype wire

//--- bench/far_side_model.sv
// Downstream neighbour taking delivered, forwarded and generated headers.
// Assumes the bench picks prompt or slow acceptance through slow.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic slow,
   output logic dlv_ready,
   output logic fwd_ready,
   output logic tx_ready
);
   logic [2:0] cnt_ff; // Stall pattern phase
   // Known levels before the first edge
   initial begin
      cnt_ff = 3'h0;
      {dlv_ready, fwd_ready, tx_ready} = 3'h0;
   end
   // Readies move at the falling edge only
   always @(negedge ref_clk) begin
      cnt_ff <= reset ? 3'h0 : cnt_ff + 3'h1;
      dlv_ready <= !slow || cnt_ff == 3'h0;
      fwd_ready <= !slow || cnt_ff == 3'h3;
      tx_ready <= !slow || cnt_ff == 3'h5;
   end
endmodule // far_side_model
`default_nettype wire

//--- bench/test_transport_header_router.sv
// Self-checking bench for the transport header router.
// Assumes far_side_model on the ready inputs and a 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_transport_header_router;
   logic ref_clk, reset, ring_mode, has_own_id, alt_id_en, tbl_wr_en, slow, saw_full;
   logic rx_valid, rx_ready, rx_maint, gen_valid, gen_wide, gen_is_resp, gen_maint;
   logic [15:0] own_id, alt_id, rx_target, rx_origin, gen_peer_id, gen_req_target;
   logic [15:0] hdr_target_ff, hdr_origin_ff;
   logic [7:0] tbl_wr_addr, rx_hop, gen_hop, hdr_hop_ff, tx_hop_ff;
   logic [3:0] tbl_wr_port, rx_ftype, gen_ftype, hdr_ftype_ff, fwd_port_ff;
   logic [1:0] rx_tt, hdr_tt_ff;
   logic hdr_maint_ff, dlv_valid_ff, dlv_ready, fwd_valid_ff, fwd_ready, tt_error_ff;
   logic gen_ready_ff, tx_valid_ff, tx_ready, tx_wide_ff, tx_maint_ff;
   logic [37:0] tx_header_ff;
   logic [3:0] tbl [256]; // Own copy of the route table
   logic [52:0] rxq [$]; // Expected routing results
   logic [51:0] txq [$]; // Expected generated headers
   int n_errors = 0;
   int checked = 0;
   transport_header_router transport_header_router_inst (.ref_clk, .reset, .ring_mode, .has_own_id,
      .own_id, .alt_id_en, .alt_id, .tbl_wr_en, .tbl_wr_addr, .tbl_wr_port, .rx_valid, .rx_ready,
      .rx_tt, .rx_ftype, .rx_target, .rx_origin, .rx_maint, .rx_hop, .hdr_tt_ff, .hdr_ftype_ff,
      .hdr_target_ff, .hdr_origin_ff, .hdr_maint_ff, .hdr_hop_ff, .dlv_valid_ff, .dlv_ready,
      .fwd_valid_ff, .fwd_ready, .fwd_port_ff, .tt_error_ff, .gen_valid, .gen_ready_ff, .gen_ftype,
      .gen_wide, .gen_is_resp, .gen_maint, .gen_peer_id, .gen_req_target, .gen_hop, .tx_valid_ff,
      .tx_ready, .tx_header_ff, .tx_wide_ff, .tx_maint_ff, .tx_hop_ff);
   far_side_model far_side_model_inst (.ref_clk, .reset, .slow, .dlv_ready, .fwd_ready, .tx_ready);
   // Counts and verdict, then stop
   task automatic test_done;
      $display("Checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One comparison
   task automatic chk(string what, logic [52:0] seen, logic [52:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bounded wait outcome
   task automatic guard(int n, int lim);
      chk("wait bound", 52'(n < lim), 52'h1);
      if (n >= lim) test_done();
   endtask
   // Offer one received header and note its expected route
   task automatic rx(logic [1:0] tt, logic [15:0] tgt, logic [15:0] org, logic mt, logic [7:0] hop);
      logic [15:0] k;
      logic [37:0] b;
      logic [52:0] e;
      logic m;
      int n;
      k = tt == 2'h0 ? 16'h00ff : 16'hffff;
      b = {tt, 4'($urandom), tgt & k, org & k};
      m = has_own_id && (((tgt ^ own_id) & k) == 0 || alt_id_en && ((tgt ^ alt_id) & k) == 0);
      if (tt[1]) e = {2'h2, 50'h0};
      else if (!ring_mode && mt && !has_own_id)
         e = hop == 8'h00 ? {mt, 6'h00, b, hop} : {mt, 2'h1, tbl[tgt[7:0]], b, hop - 8'h01};
      else if (m) e = {mt, 6'h00, b, hop};
      else e = {mt, 2'h1, ring_mode ? 4'h0 : tbl[tgt[7:0]], b, hop};
      @(negedge ref_clk);
      {rx_tt, rx_ftype, rx_target, rx_origin} = b;
      rx_maint = mt;
      rx_hop = hop;
      rx_valid = 1'b1;
      rxq.push_back(e);
      n = 0;
      while (rx_ready !== 1'b1 && n < 200) begin
         saw_full = 1'b1;
         @(negedge ref_clk);
         n++;
      end
      guard(n, 200);
   endtask
   // Ask for one generated header and note the expected form
   task automatic gen(logic w, logic rs, logic mt, logic [15:0] peer, logic [15:0] rt, logic [7:0] hop);
      logic [15:0] org;
      logic [3:0] ft;
      int n;
      ft = 4'($urandom);
      org = rs ? rt : own_id;
      @(negedge ref_clk);
      {gen_wide, gen_is_resp, gen_maint, gen_ftype} = {w, rs, mt, ft};
      {gen_peer_id, gen_req_target, gen_hop} = {peer, rt, hop};
      gen_valid = 1'b1;
      txq.push_back({4'h0, w, mt, 1'b0, w, ft, w ? {peer, org} : {peer[7:0], org[7:0], 16'h0000},
         rs && mt ? 8'hff : hop});
      n = 0;
      while (gen_ready_ff !== 1'b1 && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      guard(n, 200);
   endtask
   // Wait until every noted result was seen
   task automatic drain;
      int n;
      n = 0;
      while ((rxq.size() != 0 || txq.size() != 0) && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      guard(n, 3000);
   endtask
   // Free-running clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Results are compared in order of arrival
   always @(posedge ref_clk) begin
      if (!reset && (dlv_valid_ff && dlv_ready || fwd_valid_ff && fwd_ready || tt_error_ff)) begin
         chk("route note", 52'(rxq.size() != 0), 52'h1);
         if (rxq.size() != 0) chk("routed header", tt_error_ff ? {2'h2, 50'h0} : {hdr_maint_ff,
            fwd_valid_ff ? 2'h1 : 2'h0, fwd_valid_ff ? fwd_port_ff : 4'h0, hdr_tt_ff, hdr_ftype_ff,
            hdr_target_ff, hdr_origin_ff, hdr_hop_ff}, rxq.pop_front());
      end
      if (!reset && tx_valid_ff && tx_ready) begin
         chk("header note", 52'(txq.size() != 0), 52'h1);
         if (txq.size() != 0) chk("sent header", {4'h0, tx_wide_ff, tx_maint_ff, tx_header_ff, tx_hop_ff},
            txq.pop_front());
      end
   end
   // Main sequence
   initial begin
      int i, j;
      {reset, ring_mode, has_own_id, alt_id_en, tbl_wr_en, slow, saw_full} = 7'h40;
      {rx_valid, rx_maint, gen_valid, gen_wide, gen_is_resp, gen_maint} = 6'h00;
      {own_id, alt_id, rx_target, rx_origin, gen_peer_id, gen_req_target} = {16'h1a42, 16'h2b17, 64'h0};
      {tbl_wr_addr, rx_hop, gen_hop, tbl_wr_port, rx_ftype, gen_ftype, rx_tt} = 38'h0;
      void'($urandom(5));
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      chk("reset state", {dlv_valid_ff, fwd_valid_ff, tx_valid_ff, tt_error_ff}, 4'h0);
      for (i = 0; i < 256; i++) begin
         @(negedge ref_clk);
         tbl_wr_en = 1'b1;
         tbl_wr_addr = 8'(i);
         tbl_wr_port = 4'($urandom);
         tbl[i] = tbl_wr_port;
      end
      @(negedge ref_clk);
      tbl_wr_en = 1'b0;
      $display("Test table done");
      // Switch with id, switch without id, then ring
      for (i = 0; i < 3; i++) begin
         @(negedge ref_clk);
         {ring_mode, has_own_id, alt_id_en, slow, saw_full} = {i == 2, i != 1, i != 2, i != 0, 1'b0};
         for (j = 0; j < 24; j++)
            rx(j % 8 == 7 ? 2'h3 : j % 8 == 3 ? 2'h2 : 2'($urandom % 2),
               j % 3 == 0 ? own_id : j % 3 == 1 ? alt_id : 16'($urandom), 16'($urandom), 1'($urandom),
               j % 4 == 0 ? 8'h00 : j % 4 == 1 ? 8'h01 : 8'($urandom));
         @(negedge ref_clk);
         rx_valid = 1'b0;
         drain();
         if (i == 1) chk("buffer refused", 52'(saw_full), 52'h1);
         chk("buffer ready", 52'(rx_ready), 52'h1);
         $display("Test routing mode %0d done", i);
      end
      for (j = 0; j < 24; j++) begin
         slow = j[3];
         gen(1'($urandom), 1'($urandom), 1'($urandom), 16'($urandom), 16'($urandom), 8'($urandom));
      end
      @(negedge ref_clk);
      gen_valid = 1'b0;
      drain();
      $display("Test generation done");
      test_done();
   end
endmodule // test_transport_header_router
`default_nettype wire
